// file: src/wesb_cfg.svh
// offsets, field positions and reset values of the wake event status bank
`ifndef WESB_CFG_SVH
`define WESB_CFG_SVH

`define WESB_ADDR_W           8
`define WESB_DATA_W           8

`define WESB_OFS_GPIO5_STS    8'h08
`define WESB_OFS_FUNC_STS     8'h09
`define WESB_OFS_CTRL         8'h0D
`define WESB_OFS_GPIO5_EN     8'h0E
`define WESB_OFS_FUNC_EN      8'h0F
`define WESB_OFS_IRQ_STS      8'h10
`define WESB_OFS_IRQ_MASK     8'h11

`define WESB_RST_GPIO5_STS    8'h00
`define WESB_RST_FUNC_STS     8'h01
`define WESB_RST_EN           8'h00
`define WESB_RST_CTRL         8'h00
`define WESB_RST_IRQ          8'h00
`define WESB_RST_SYNC         12'h100

`define WESB_BIT_GLOBAL_EN    0
`define WESB_BIT_PAR          0
`define WESB_BIT_IRQ_GPIO5    0
`define WESB_BIT_IRQ_FUNC     1
`define WESB_BIT_IRQ_WAKE     2

`endif

// file: src/wesb_pkg.sv
// types shared by the wake event status bank
package wesb_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wesb_bus_req_t;

    // packed msb first so that smbus lands on bit 7 and midi on bit 1
    typedef struct packed {
        logic smbus_irq_flag;
        logic watchdog_irq_flag;
        logic keyboard_irq_flag;
        logic mouse_irq_flag;
        logic floppy_irq_flag;
        logic serial_port_irq_flag;
        logic midi_irq_flag;
    } wesb_func_evt_t;

    typedef struct packed {
        logic soft_reset;
        logic hard_reset;
        logic main_power_on_reset;
    } wesb_other_rst_t;

endpackage

// file: src/wesb_sync.sv
// two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module wesb_sync
    import wesb_pkg::*;
#(
    parameter int           W       = 12,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// file: src/wesb_w1c_reg.sv
// sticky write-one-to-clear status register with per-bit force
`timescale 1ns/1ps
module wesb_w1c_reg
    import wesb_pkg::*;
#(
    parameter int           W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic [W-1:0] force_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] sts_q;
    logic [W-1:0] sts_d;

    // set and force are ordered after the clear so that they win
    always_comb begin
        sts_d = (sts_q & ~clr_i) | set_i | force_i;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sts_q <= RST_VAL;
        end else begin
            sts_q <= sts_d;
        end
    end

    assign q_o = sts_q;
endmodule

// file: src/wesb_top.sv
// wake event status bank: sticky wake and function status, enables, wake output
`timescale 1ns/1ps
`include "wesb_cfg.svh"
module wesb_top
    import wesb_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire wesb_bus_req_t   bus_req,
    output logic [7:0]           bus_rdata,
    input  wire logic [7:0]      gpio_group5_pin,
    input  wire wesb_func_evt_t  func_evt,
    input  wire logic            parallel_port_active,
    input  wire logic            parallel_ack_n,
    input  wire wesb_other_rst_t other_rst,
    output logic                 wake_request_out_n,
    output logic                 irq
);
    // pin side synchronisation: gpio pins, acknowledge and the other resets
    logic [11:0]     pin_async;
    logic [11:0]     pin_sync;
    logic [7:0]      gpio_sync;
    logic            ack_n_sync;
    wesb_other_rst_t rst_sync;

    assign pin_async = {other_rst, parallel_ack_n, gpio_group5_pin};

    wesb_sync #(
        .W       (12),
        .RST_VAL (`WESB_RST_SYNC)
    ) u_sync (
        .clk     (clk),
        .reset   (reset),
        .async_i (pin_async),
        .sync_o  (pin_sync)
    );

    assign gpio_sync  = pin_sync[7:0];
    assign ack_n_sync = pin_sync[8];
    assign rst_sync   = wesb_other_rst_t'(pin_sync[11:9]);

    // transition detector on the synchronised gpio pins
    // edges ignored until the synchroniser has refilled, so a pin high over reset is no event
    logic [7:0] gpio_prev_q;
    logic [7:0] gpio_prev_d;
    logic [2:0] gpio_arm_q;
    logic [2:0] gpio_arm_d;
    logic [7:0] gpio_evt;

    always_comb begin
        gpio_prev_d = gpio_sync;
        gpio_arm_d  = {gpio_arm_q[1:0], 1'b1};
        gpio_evt    = gpio_arm_q[2] ? (gpio_sync ^ gpio_prev_q) : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gpio_prev_q <= 8'h00;
            gpio_arm_q  <= 3'h0;
        end else begin
            gpio_prev_q <= gpio_prev_d;
            gpio_arm_q  <= gpio_arm_d;
        end
    end

    // register bus decode
    logic       wr_gpio_sts;
    logic       wr_func_sts;
    logic       wr_ctrl;
    logic       wr_gpio_en;
    logic       wr_func_en;
    logic       wr_irq_mask;
    logic       rd_irq_sts;
    logic [7:0] gpio_clr;
    logic [7:0] func_clr;

    always_comb begin
        wr_gpio_sts = bus_req.wr && (bus_req.addr == `WESB_OFS_GPIO5_STS);
        wr_func_sts = bus_req.wr && (bus_req.addr == `WESB_OFS_FUNC_STS);
        wr_ctrl     = bus_req.wr && (bus_req.addr == `WESB_OFS_CTRL);
        wr_gpio_en  = bus_req.wr && (bus_req.addr == `WESB_OFS_GPIO5_EN);
        wr_func_en  = bus_req.wr && (bus_req.addr == `WESB_OFS_FUNC_EN);
        wr_irq_mask = bus_req.wr && (bus_req.addr == `WESB_OFS_IRQ_MASK);
        rd_irq_sts  = bus_req.rd && (bus_req.addr == `WESB_OFS_IRQ_STS);
        gpio_clr    = wr_gpio_sts ? bus_req.wdata : 8'h00;
        func_clr    = wr_func_sts ? bus_req.wdata : 8'h00;
    end

    // sources of the function status register
    logic       other_rst_any;
    logic       par_set;
    logic [7:0] func_set;
    logic [7:0] func_force;

    always_comb begin
        other_rst_any = |rst_sync;
        par_set       = parallel_port_active && !ack_n_sync;
        func_set      = {func_evt, par_set};
        func_force    = 8'h00;
        // bits 7..1 are never forced, bit 0 is forced by the other resets and while the parallel port is inactive
        func_force[`WESB_BIT_PAR] = other_rst_any || !parallel_port_active;
    end

    // the status registers: reset only by the standby reset on the reset port, otherwise cleared by writing one
    logic [7:0] gpio_sts;
    logic [7:0] func_sts;

    wesb_w1c_reg #(
        .W       (8),
        .RST_VAL (`WESB_RST_GPIO5_STS)
    ) u_gpio_sts (
        .clk     (clk),
        .reset   (reset),
        .set_i   (gpio_evt),
        .clr_i   (gpio_clr),
        .force_i (8'h00),
        .q_o     (gpio_sts)
    );

    wesb_w1c_reg #(
        .W       (8),
        .RST_VAL (`WESB_RST_FUNC_STS)
    ) u_func_sts (
        .clk     (clk),
        .reset   (reset),
        .set_i   (func_set),
        .clr_i   (func_clr),
        .force_i (func_force),
        .q_o     (func_sts)
    );

    // enables, control and interrupt mask
    logic [7:0] gpio_en_q;
    logic [7:0] gpio_en_d;
    logic [7:0] func_en_q;
    logic [7:0] func_en_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_mask_d;

    always_comb begin
        gpio_en_d  = wr_gpio_en ? bus_req.wdata : gpio_en_q;
        func_en_d  = wr_func_en ? bus_req.wdata : func_en_q;
        ctrl_d     = wr_ctrl ? (bus_req.wdata & 8'h01) : ctrl_q;
        irq_mask_d = wr_irq_mask ? (bus_req.wdata & 8'h07) : irq_mask_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gpio_en_q  <= `WESB_RST_EN;
            func_en_q  <= `WESB_RST_EN;
            ctrl_q     <= `WESB_RST_CTRL;
            irq_mask_q <= `WESB_RST_IRQ;
        end else begin
            gpio_en_q  <= gpio_en_d;
            func_en_q  <= func_en_d;
            ctrl_q     <= ctrl_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // wake output, open-drain style active low request
    logic wake_req;
    logic wake_n_q;
    logic wake_n_d;

    always_comb begin
        wake_req = ctrl_q[`WESB_BIT_GLOBAL_EN] &&
                   (|((gpio_sts & gpio_en_q) | (func_sts & func_en_q)));
        wake_n_d = !wake_req;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wake_n_q <= 1'b1;
        end else begin
            wake_n_q <= wake_n_d;
        end
    end

    // block interrupt: sticky events, read-to-clear, masked onto irq
    logic [7:0] irq_sts_q;
    logic [7:0] irq_sts_d;
    logic [7:0] irq_evt;
    logic       irq_q;
    logic       irq_d;

    always_comb begin
        irq_evt = 8'h00;
        irq_evt[`WESB_BIT_IRQ_GPIO5] = |(gpio_evt & ~gpio_sts);
        irq_evt[`WESB_BIT_IRQ_FUNC]  = |(func_set & ~func_sts);
        irq_evt[`WESB_BIT_IRQ_WAKE]  = wake_req && wake_n_q;
        // a read clears, an event in the same cycle survives
        irq_sts_d = (rd_irq_sts ? 8'h00 : irq_sts_q) | irq_evt;
        irq_d     = |(irq_sts_d & irq_mask_q);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_sts_q <= `WESB_RST_IRQ;
            irq_q     <= 1'b0;
        end else begin
            irq_sts_q <= irq_sts_d;
            irq_q     <= irq_d;
        end
    end

    // read data, valid in the cycle after the read strobe
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `WESB_OFS_GPIO5_STS: rdata_d = gpio_sts;
                `WESB_OFS_FUNC_STS:  rdata_d = func_sts;
                `WESB_OFS_CTRL:      rdata_d = ctrl_q;
                `WESB_OFS_GPIO5_EN:  rdata_d = gpio_en_q;
                `WESB_OFS_FUNC_EN:   rdata_d = func_en_q;
                `WESB_OFS_IRQ_STS:   rdata_d = irq_sts_q;
                `WESB_OFS_IRQ_MASK:  rdata_d = irq_mask_q;
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata          = rdata_q;
    assign wake_request_out_n = wake_n_q;
    assign irq                = irq_q;

    // checks
    AST_GPIO_SET: assert property (@(posedge clk) disable iff (reset)
        (gpio_evt != 8'h00) |=> ((gpio_sts & $past(gpio_evt)) == $past(gpio_evt)))
        else $error("gpio event did not set its status bit");

    AST_GPIO_HOLD: assert property (@(posedge clk) disable iff (reset)
        ##1 ((($past(gpio_sts) & ~$past(gpio_clr)) & ~gpio_sts) == 8'h00))
        else $error("gpio status bit dropped without a clear");

    AST_GPIO_MAP: assert property (@(posedge clk) disable iff (reset)
        ##1 ((gpio_sts & ~$past(gpio_sts) & ~$past(gpio_evt)) == 8'h00))
        else $error("gpio status bit set without its own pin");

    AST_GPIO_NO_RST: assert property (@(posedge clk) disable iff (reset)
        (other_rst_any && (gpio_clr == 8'h00)) |=> (gpio_sts == ($past(gpio_sts) | $past(gpio_evt))))
        else $error("gpio status changed by a non-standby reset");

    AST_GPIO_W1C: assert property (@(posedge clk) disable iff (reset)
        (gpio_clr != 8'h00) |=> ((gpio_sts & $past(gpio_clr) & ~$past(gpio_evt)) == 8'h00))
        else $error("gpio write of one did not clear");

    AST_RST_VALUES: assert property (@(posedge clk)
        $past(reset) |-> ((func_sts == `WESB_RST_FUNC_STS) && (gpio_sts == `WESB_RST_GPIO5_STS)))
        else $error("status reset value wrong");

    AST_FORCE_BIT0: assert property (@(posedge clk) disable iff (reset)
        other_rst_any |=> func_sts[`WESB_BIT_PAR])
        else $error("bit 0 not forced by another reset");

    AST_PAR_IDLE: assert property (@(posedge clk) disable iff (reset)
        !parallel_port_active |=> func_sts[`WESB_BIT_PAR])
        else $error("parallel flag not held while inactive");

    AST_PAR_ACK: assert property (@(posedge clk) disable iff (reset)
        (parallel_port_active && !ack_n_sync) |=> func_sts[`WESB_BIT_PAR])
        else $error("acknowledge did not set the parallel flag");

    AST_FUNC_MAP: assert property (@(posedge clk) disable iff (reset)
        ##1 (((($past(func_set) | $past(func_sts)) & ~$past(func_clr)) & ~func_sts & 8'hFE) == 8'h00))
        else $error("function event lost its status bit");

    AST_FUNC_NO_RST: assert property (@(posedge clk) disable iff (reset)
        (other_rst_any && (func_clr == 8'h00)) |=>
        (func_sts[7:1] == ($past(func_sts[7:1]) | $past(func_set[7:1]))))
        else $error("function bits changed by a non-standby reset");

    AST_FUNC_W1C: assert property (@(posedge clk) disable iff (reset)
        (func_clr != 8'h00) |=> ((func_sts & $past(func_clr & ~func_set & ~func_force)) == 8'h00))
        else $error("function write of one did not clear");

    AST_WAKE_OUT: assert property (@(posedge clk) disable iff (reset)
        ##1 (wake_request_out_n == !($past(ctrl_q[0]) &&
        (|(($past(gpio_sts) & $past(gpio_en_q)) | ($past(func_sts) & $past(func_en_q)))))))
        else $error("wake output does not match status and enables");

    AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
        ((gpio_clr & gpio_evt) != 8'h00) |=>
        ((gpio_sts & $past(gpio_clr & gpio_evt)) == $past(gpio_clr & gpio_evt)))
        else $error("same-cycle clear beat the event");

    AST_FUNC_SET_WINS: assert property (@(posedge clk) disable iff (reset)
        ((func_clr & func_set) != 8'h00) |=>
        ((func_sts & $past(func_clr & func_set)) == $past(func_clr & func_set)))
        else $error("same-cycle clear beat a function event");

    AST_PAR_CLR: assert property (@(posedge clk) disable iff (reset)
        (parallel_port_active && ack_n_sync && !other_rst_any && func_clr[`WESB_BIT_PAR]) |=>
        !func_sts[`WESB_BIT_PAR])
        else $error("parallel flag write of one did not clear");

    AST_WAKE_GLOBAL: assert property (@(posedge clk) disable iff (reset)
        !ctrl_q[`WESB_BIT_GLOBAL_EN] |=> wake_request_out_n)
        else $error("wake output low without the global enable");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (reset)
        !$past(bus_req.rd) |-> (bus_rdata == 8'h00))
        else $error("read data not zero outside a read");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (reset)
        irq == (|(irq_sts_q & $past(irq_mask_q))))
        else $error("interrupt output does not follow masked status");

    AST_IRQ_READ_CLEAR: assert property (@(posedge clk) disable iff (reset)
        (rd_irq_sts && (irq_evt == 8'h00)) |=> (irq_sts_q == 8'h00))
        else $error("interrupt status not cleared by its read");

    AST_WAKE_IRQ: assert property (@(posedge clk) disable iff (reset)
        $fell(wake_request_out_n) |-> irq_sts_q[`WESB_BIT_IRQ_WAKE])
        else $error("wake request did not raise its interrupt status");

endmodule

// file: test/wesb_top_tb.sv
// self-checking testbench of the wake event status bank
`timescale 1ns/1ps
module wesb_top_tb;
    import wesb_pkg::*;

    logic            clk;
    logic            reset;
    wesb_bus_req_t   bus_req;
    logic [7:0]      bus_rdata;
    logic [7:0]      gpio_group5_pin;
    wesb_func_evt_t  func_evt;
    logic            parallel_port_active;
    logic            parallel_ack_n;
    wesb_other_rst_t other_rst;
    logic            wake_request_out_n;
    logic            irq;
    int              err_count;
    int              checks;
    logic [7:0]      rd_val;

    wesb_top DUT (
        .clk                  (clk),
        .reset                (reset),
        .bus_req              (bus_req),
        .bus_rdata            (bus_rdata),
        .gpio_group5_pin      (gpio_group5_pin),
        .func_evt             (func_evt),
        .parallel_port_active (parallel_port_active),
        .parallel_ack_n       (parallel_ack_n),
        .other_rst            (other_rst),
        .wake_request_out_n   (wake_request_out_n),
        .irq                  (irq)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= {a, d, 2'b10};
        @(posedge clk);
        bus_req <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge clk);
        bus_req <= '0;
        #1 d = bus_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        bus_rd(a, d);
        check(name, exp, d);
    endtask

    task automatic wait_wake(input logic exp);
        int n;
        n = 0;
        while (wake_request_out_n !== exp && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        check("wake_request_out_n", {7'h00, exp}, {7'h00, wake_request_out_n});
        if (wake_request_out_n !== exp) final_report();
    endtask

    task automatic t_reset_values();
        rd_chk(8'h08, 8'h00, "gpio5 status after reset");
        rd_chk(8'h09, 8'h01, "function status after reset");
        rd_chk(8'h20, 8'h00, "unmapped read");
        check("wake out idle", 8'h01, {7'h00, wake_request_out_n});
        check("irq idle", 8'h00, {7'h00, irq});
    endtask

    // enables are all off here, so recording must not depend on them
    task automatic t_gpio_map();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            gpio_group5_pin[i] <= 1'b1;
            cycles(6);
            rd_chk(8'h08, 8'h01 << i, "gpio5 status set");
            bus_wr(8'h08, ~(8'h01 << i));
            rd_chk(8'h08, 8'h01 << i, "gpio5 status after zero write");
            bus_wr(8'h08, 8'h01 << i);
            rd_chk(8'h08, 8'h00, "gpio5 status after clear");
        end
    endtask

    task automatic t_func_map();
        for (int i = 1; i < 8; i++) begin
            @(posedge clk);
            func_evt <= wesb_func_evt_t'(7'h01 << (i - 1));
            @(posedge clk);
            func_evt <= '0;
            rd_chk(8'h09, (8'h01 << i) | 8'h01, "function status set");
            bus_wr(8'h09, 8'hFF);
            rd_chk(8'h09, 8'h01, "function status after clear");
        end
    endtask

    task automatic t_parallel();
        @(posedge clk);
        parallel_port_active <= 1'b1;
        cycles(3);
        bus_wr(8'h09, 8'h01);
        rd_chk(8'h09, 8'h00, "parallel flag ack idle");
        @(posedge clk);
        parallel_ack_n <= 1'b0;
        @(posedge clk);
        parallel_ack_n <= 1'b1;
        cycles(4);
        rd_chk(8'h09, 8'h01, "parallel flag after ack");
        bus_wr(8'h09, 8'h01);
        rd_chk(8'h09, 8'h00, "parallel flag cleared");
    endtask

    task automatic t_other_resets();
        @(posedge clk);
        gpio_group5_pin[0] <= 1'b0;
        func_evt           <= wesb_func_evt_t'(7'h04);
        @(posedge clk);
        func_evt <= '0;
        cycles(6);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            other_rst <= wesb_other_rst_t'(3'h1 << k);
            cycles(2);
            other_rst <= '0;
            cycles(4);
            rd_chk(8'h09, 8'h09, "function status over other reset");
            rd_chk(8'h08, 8'h01, "gpio5 status over other reset");
            bus_wr(8'h09, 8'h01);
        end
    endtask

    task automatic t_wake_irq();
        bus_wr(8'h0E, 8'h01);
        cycles(3);
        check("wake out without global enable", 8'h01, {7'h00, wake_request_out_n});
        bus_wr(8'h11, 8'h04);
        rd_chk(8'h11, 8'h04, "irq mask");
        bus_wr(8'h0D, 8'h01);
        wait_wake(1'b0);
        cycles(2);
        check("irq raised", 8'h01, {7'h00, irq});
        bus_rd(8'h10, rd_val);
        check("irq status wake bit", 8'h04, rd_val & 8'h04);
        cycles(2);
        check("irq after status read", 8'h00, {7'h00, irq});
        bus_wr(8'h08, 8'h01);
        wait_wake(1'b1);
        bus_wr(8'h0F, 8'h08);
        wait_wake(1'b0);
        bus_wr(8'h0F, 8'h00);
        wait_wake(1'b1);
        bus_wr(8'h0D, 8'h00);
    endtask

    task automatic t_same_cycle();
        bus_wr(8'h09, 8'h08);
        rd_chk(8'h09, 8'h00, "function status cleared");
        @(posedge clk);
        bus_req  <= {8'h09, 8'h08, 2'b10};
        func_evt <= wesb_func_evt_t'(7'h04);
        @(posedge clk);
        bus_req  <= '0;
        func_evt <= '0;
        rd_chk(8'h09, 8'h08, "event against same-cycle clear");
        // the pin edge reaches the status logic two edges after the pin moves
        @(posedge clk);
        gpio_group5_pin[0] <= 1'b1;
        cycles(2);
        bus_req <= {8'h08, 8'h01, 2'b10};
        @(posedge clk);
        bus_req <= '0;
        rd_chk(8'h08, 8'h01, "pin edge against same-cycle clear");
    endtask

    // pins stay high over the reset, so the refilling synchroniser must not look like an edge
    task automatic t_standby_reset();
        @(posedge clk);
        gpio_group5_pin <= 8'hFF;
        cycles(6);
        reset <= 1'b1;
        cycles(3);
        reset <= 1'b0;
        rd_chk(8'h08, 8'h00, "gpio5 status after standby reset");
        rd_chk(8'h09, 8'h01, "function status after standby reset");
        cycles(4);
        rd_chk(8'h08, 8'h00, "gpio5 status after synchroniser refill");
    endtask

    initial begin
        err_count            = 0;
        checks               = 0;
        reset                = 1'b1;
        bus_req              = '0;
        gpio_group5_pin      = 8'h00;
        func_evt             = '0;
        parallel_port_active = 1'b0;
        parallel_ack_n       = 1'b1;
        other_rst            = '0;
        cycles(2);
        reset <= 1'b0;
        t_reset_values();
        t_gpio_map();
        t_func_map();
        t_parallel();
        t_other_resets();
        t_wake_irq();
        t_same_cycle();
        t_standby_reset();
        final_report();
    end
endmodule
